// ### inc/align_pkg.sv
package align_pkg;

  localparam int unsigned ADDR_W       = 13;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CNT_W        = 5;

  // Register addresses on the serial port
  localparam logic [12:0] ADDR_ALIGN_CTRL = 13'h003a;
  localparam logic [12:0] ADDR_PIN_CTRL   = 13'h0059;

  // Serial frame: 16 instruction bits, then data bytes MSB first
  localparam logic [4:0]  INSTR_LAST   = 5'h0f;
  localparam logic [4:0]  BYTE_LAST    = 5'h07;
  localparam int unsigned INSTR_RW_BIT = 14;
  localparam int unsigned INSTR_ADDR_HI = 11;
  localparam logic [12:0] ADDR_STEP    = 13'h0001;

  // Field widths inside the data byte (fields start at bit 0)
  localparam int unsigned ALIGN_CTRL_W = 3;
  localparam int unsigned PIN_CTRL_W   = 2;

  typedef struct packed {
    logic next_only;   // Bit 2
    logic div_en;      // Bit 1
    logic buf_en;      // Bit 0
  } align_ctrl_type;

  typedef struct packed {
    logic edge_mode;   // Bit 1: 0 level, 1 edge
    logic rising;      // Bit 0: 0 falling, 1 rising
  } pin_ctrl_type;

  localparam align_ctrl_type ALIGN_CTRL_RESET = 3'h0;
  localparam pin_ctrl_type   PIN_CTRL_RESET   = 2'h0;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b001,
    PH_INSTR = 3'b010,
    PH_DATA  = 3'b100
  } phase_type;

endpackage

// ### hw/align_pulse_detect.sv
`timescale 1ns/10ps
module align_pulse_detect (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  enable_i,
  input  wire align_pkg::pin_ctrl_type mode_i,
  input  wire logic                  align_pulse_i,
  output logic                       detect_o
);

  logic [2:0] stage;
  logic       level_hit;
  logic       rise_hit;
  logic       fall_hit;
  logic       edge_hit;
  logic       next_detect;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], align_pulse_i};
    end
  end

  assign level_hit   = stage[1];
  assign rise_hit    = stage[1] & ~stage[2];
  assign fall_hit    = ~stage[1] & stage[2];
  assign edge_hit    = mode_i.rising ? rise_hit : fall_hit;
  assign next_detect = enable_i & (mode_i.edge_mode ? edge_hit : level_hit);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      detect_o <= 1'b0;
    end else begin
      detect_o <= next_detect;
    end
  end

  a_idle_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
    !enable_i |=> !detect_o) else $error("detector fired while buffer disabled");
  a_level_high: assert property (@(posedge clk_i) disable iff (reset_i)
    (enable_i && !mode_i.edge_mode && stage[1]) |=> detect_o)
    else $error("level mode missed a high input");
  a_edge_only: assert property (@(posedge clk_i) disable iff (reset_i)
    (detect_o && $past(mode_i.edge_mode)) |-> $past(stage[1] != stage[2]))
    else $error("edge mode fired without an edge");
  a_edge_dir: assert property (@(posedge clk_i) disable iff (reset_i)
    (detect_o && $past(mode_i.edge_mode)) |-> ($past(stage[1]) == $past(mode_i.rising)))
    else $error("edge detected with wrong polarity");

endmodule

// ### hw/divider_alignment_control.sv
`timescale 1ns/10ps
module divider_alignment_control (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic align_pulse_i,
  input  wire logic spi_sclk_i,
  input  wire logic spi_cs_n_i,
  input  wire logic spi_sdio_i,
  output logic      divider_align_o,
  output logic      align_buffer_en_o,
  output logic      spi_sdio_o,
  output logic      spi_sdio_oe_o
);

  // Serial pin synchronisers
  logic [2:0]                    sclk_stage;
  logic [1:0]                    cs_stage;
  logic [1:0]                    sdio_stage;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_stage <= 3'h0;
      cs_stage   <= 2'h3;
      sdio_stage <= 2'h0;
    end else begin
      sclk_stage <= {sclk_stage[1:0], spi_sclk_i};
      cs_stage   <= {cs_stage[0], spi_cs_n_i};
      sdio_stage <= {sdio_stage[0], spi_sdio_i};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic sdio_in;

  assign sclk_rise = sclk_stage[1] & ~sclk_stage[2];
  assign sclk_fall = ~sclk_stage[1] & sclk_stage[2];
  assign cs_active = ~cs_stage[1];
  assign sdio_in   = sdio_stage[1];

  // Registers
  align_pkg::align_ctrl_type     ctrl;
  align_pkg::pin_ctrl_type       pin_ctrl;
  align_pkg::align_ctrl_type     next_ctrl;
  align_pkg::pin_ctrl_type       next_pin_ctrl;

  // Serial frame state
  align_pkg::phase_type          phase;
  logic [align_pkg::CNT_W-1:0]   bit_cnt;
  logic [15:0]                   shift_in;
  logic [align_pkg::ADDR_W-1:0]  addr;
  logic                          rd_mode;
  logic [align_pkg::DATA_W-1:0]  shift_out;
  logic                          wr_en;
  logic [align_pkg::ADDR_W-1:0]  wr_addr;
  logic [align_pkg::DATA_W-1:0]  wr_data;

  function automatic logic [7:0] read_byte(
    input logic [12:0]                 a,
    input align_pkg::align_ctrl_type   c,
    input align_pkg::pin_ctrl_type     p
  );
    logic [7:0] r;
    r = 8'h00;
    if (a == align_pkg::ADDR_ALIGN_CTRL) begin
      r[align_pkg::ALIGN_CTRL_W-1:0] = c;
    end else if (a == align_pkg::ADDR_PIN_CTRL) begin
      r[align_pkg::PIN_CTRL_W-1:0] = p;
    end
    return r;
  endfunction

  logic [15:0]                   instr_word;
  logic [align_pkg::ADDR_W-1:0]  instr_addr;
  logic [align_pkg::ADDR_W-1:0]  addr_down;
  logic [7:0]                    data_byte;
  logic                          instr_done;
  logic                          byte_done;

  assign instr_word = {shift_in[14:0], sdio_in};
  assign instr_addr = instr_word[align_pkg::ADDR_W-1:0];
  assign addr_down  = addr - align_pkg::ADDR_STEP;
  assign data_byte  = {shift_in[6:0], sdio_in};
  assign instr_done = (phase == align_pkg::PH_INSTR) && sclk_rise
                      && (bit_cnt == align_pkg::INSTR_LAST);
  assign byte_done  = (phase == align_pkg::PH_DATA) && sclk_rise
                      && (bit_cnt == align_pkg::BYTE_LAST);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase <= align_pkg::PH_IDLE;
      bit_cnt <= 5'h00;
      shift_in <= 16'h0000;
      addr <= 13'h0000;
      rd_mode <= 1'b0;
      shift_out <= 8'h00;
      spi_sdio_o <= 1'b0;
      spi_sdio_oe_o <= 1'b0;
    end else if (!cs_active) begin
      phase <= align_pkg::PH_IDLE;
      bit_cnt <= 5'h00;
      spi_sdio_oe_o <= 1'b0;
    end else begin
      unique case (phase)
        align_pkg::PH_IDLE: begin
          phase <= align_pkg::PH_INSTR;
          bit_cnt <= 5'h00;
        end
        align_pkg::PH_INSTR: begin
          if (sclk_rise) begin
            shift_in <= instr_word;
            bit_cnt <= bit_cnt + 5'h01;
          end
          if (instr_done) begin
            phase <= align_pkg::PH_DATA;
            bit_cnt <= 5'h00;
            rd_mode <= instr_word[align_pkg::INSTR_RW_BIT + 1];
            addr <= instr_addr;
            shift_out <= read_byte(instr_addr, ctrl, pin_ctrl);
          end
        end
        align_pkg::PH_DATA: begin
          if (sclk_rise) begin
            shift_in <= instr_word;
            bit_cnt <= bit_cnt + 5'h01;
          end
          if (byte_done) begin
            bit_cnt <= 5'h00;
            addr <= addr_down;
            shift_out <= read_byte(addr_down, ctrl, pin_ctrl);
          end else if (sclk_fall && rd_mode) begin
            spi_sdio_o <= shift_out[7];
            spi_sdio_oe_o <= 1'b1;
            shift_out <= {shift_out[6:0], 1'b0};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_en <= 1'b0;
      wr_addr <= 13'h0000;
      wr_data <= 8'h00;
    end else begin
      wr_en <= byte_done && !rd_mode;
      wr_addr <= addr;
      wr_data <= data_byte;
    end
  end

  // Alignment path
  logic detect;
  logic qualified;
  logic oneshot_fire;
  logic wr_align;
  logic wr_pin;

  align_pulse_detect u_detect (
    .clk_i         (clk_i),
    .reset_i       (reset_i),
    .enable_i      (ctrl.buf_en),
    .mode_i        (pin_ctrl),
    .align_pulse_i (align_pulse_i),
    .detect_o      (detect)
  );

  assign qualified    = ctrl.buf_en & ctrl.div_en & detect;
  assign oneshot_fire = qualified & ctrl.next_only;
  assign wr_align     = wr_en && (wr_addr == align_pkg::ADDR_ALIGN_CTRL);
  assign wr_pin       = wr_en && (wr_addr == align_pkg::ADDR_PIN_CTRL);

  always_comb begin
    next_ctrl = ctrl;
    if (wr_align) begin
      next_ctrl = align_pkg::align_ctrl_type'(wr_data[align_pkg::ALIGN_CTRL_W-1:0]);
    end else if (oneshot_fire) begin
      next_ctrl.div_en = 1'b0;
    end
  end

  assign next_pin_ctrl = wr_pin
                         ? align_pkg::pin_ctrl_type'(wr_data[align_pkg::PIN_CTRL_W-1:0])
                         : pin_ctrl;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl <= align_pkg::ALIGN_CTRL_RESET;
      pin_ctrl <= align_pkg::PIN_CTRL_RESET;
      divider_align_o <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      pin_ctrl <= next_pin_ctrl;
      divider_align_o <= qualified;
    end
  end

  assign align_buffer_en_o = ctrl.buf_en;

  a_master_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    divider_align_o |-> $past(ctrl.buf_en)) else $error("realign without master enable");
  a_divider_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    divider_align_o |-> $past(ctrl.div_en)) else $error("realign without divider enable");
  a_continuous_pass: assert property (@(posedge clk_i) disable iff (reset_i)
    (ctrl.buf_en && ctrl.div_en && !ctrl.next_only && detect) |=> divider_align_o ##1 1'b1)
    else $error("continuous mode dropped a pulse");
  a_oneshot_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    (oneshot_fire && !wr_align) |=> (!ctrl.div_en && divider_align_o))
    else $error("one-shot did not clear divider enable");
  a_oneshot_once: assert property (@(posedge clk_i) disable iff (reset_i)
    (divider_align_o && $past(ctrl.next_only) && !$past(wr_align)) |=> !divider_align_o)
    else $error("one-shot realigned twice");
  a_pin_write: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_pin |=> (pin_ctrl == $past(wr_data[align_pkg::PIN_CTRL_W-1:0])))
    else $error("pin control write lost");

endmodule

// ### tb/align_host_model.sv
`timescale 1ns/10ps
module align_host_model (
  input  wire logic clk_i,
  input  wire logic dut_sdio_i,
  input  wire logic dut_sdio_oe_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdio_line_o,
  output logic      pulse_o
);
  logic host_oe;
  logic host_bit;
  logic last;

  // Undriven line toggles so a stale bit never reads as good
  assign sdio_line_o = dut_sdio_oe_i ? dut_sdio_i : (host_oe ? host_bit : ~last);

  always @(posedge clk_i) begin
    last <= sdio_line_o;
  end

  // Port stays idle between frames; pulse and host data start low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    pulse_o = 1'b0;
    host_oe = 1'b0;
    host_bit = 1'b0;
    last = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // One frame: instruction then one data byte, 5 clk per half period
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [23:0] frame;
    frame = {rd, 2'h0, addr, wdata};
    rdata = 8'h00;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    wait_clk(2);
    for (int i = 23; i >= 0; i--) begin
      host_oe = !(rd && i < 8);
      host_bit = frame[i];
      wait_clk(5);
      if (i < 8) rdata[i] = sdio_line_o;
      sclk_o = 1'b1;
      wait_clk(5);
      sclk_o = 1'b0;
    end
    host_oe = 1'b0;
    wait_clk(5);
    cs_n_o = 1'b1;
    wait_clk(8);
  endtask

  task automatic pulse(input int width);
    @(negedge clk_i);
    pulse_o = 1'b1;
    wait_clk(width);
    pulse_o = 1'b0;
    wait_clk(10);
  endtask
endmodule

// ### tb/divider_alignment_control_test.sv
`timescale 1ns/10ps
module divider_alignment_control_test;
  logic       clk_i = 1'b0;
  logic       reset_i = 1'b1;
  wire        sclk;
  wire        cs_n;
  wire        sdio_line;
  wire        pulse;
  wire        div_align;
  wire        buf_en;
  wire        dut_sdio;
  wire        dut_oe;
  int         mismatches = 0;
  int         n_compared = 0;
  int         cycles = 0;
  logic [7:0] hits = 8'h00;
  logic [7:0] base = 8'h00;
  localparam logic [12:0] CTRL = align_pkg::ADDR_ALIGN_CTRL;
  localparam logic [12:0] PIN = align_pkg::ADDR_PIN_CTRL;

  always #4 clk_i = ~clk_i;

  divider_alignment_control u_divider_alignment_control (
    .clk_i(clk_i), .reset_i(reset_i), .align_pulse_i(pulse), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_sdio_i(sdio_line), .divider_align_o(div_align),
    .align_buffer_en_o(buf_en), .spi_sdio_o(dut_sdio), .spi_sdio_oe_o(dut_oe));

  align_host_model u_align_host_model (
    .clk_i(clk_i), .dut_sdio_i(dut_sdio), .dut_sdio_oe_i(dut_oe), .sclk_o(sclk),
    .cs_n_o(cs_n), .sdio_line_o(sdio_line), .pulse_o(pulse));

  // Realign pulses counted where the output has settled
  always @(negedge clk_i) begin
    if (div_align === 1'b1) hits <= hits + 8'h01;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_align_host_model.xfer(1'b0, a, d, unused);
    @(negedge clk_i);
    base = hits;
  endtask

  task automatic rdchk(input string name, input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] r;
    u_align_host_model.xfer(1'b1, a, 8'h00, r);
    check(name, r, exp);
  endtask

  task automatic pulses(input int n, input int width);
    repeat (n) u_align_host_model.pulse(width);
  endtask

  initial begin
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rdchk("ctrl_reset", CTRL, 8'h00);
    rdchk("pin_reset", PIN, 8'h00);
    wr(13'h0010, 8'hff);
    rdchk("unmapped", 13'h0010, 8'h00);
    wr(PIN, 8'hff);
    rdchk("pin_reserved", PIN, 8'h03);
    $display("test registers done");
    wr(CTRL, 8'h06);
    pulses(1, 6);
    check("no_master", hits - base, 8'h00);
    check("buf_off", {7'h00, buf_en}, 8'h00);
    wr(CTRL, 8'h01);
    pulses(1, 6);
    check("no_div_en", hits - base, 8'h00);
    check("buf_on", {7'h00, buf_en}, 8'h01);
    wr(CTRL, 8'h03);
    pulses(2, 6);
    check("rising_cont", hits - base, 8'h02);
    wr(PIN, 8'h02);
    pulses(1, 6);
    check("falling", hits - base, 8'h01);
    wr(PIN, 8'h00);
    pulses(1, 7);
    check("level", hits - base, 8'h07);
    $display("test continuous done");
    wr(PIN, 8'h03);
    wr(CTRL, 8'h07);
    pulses(2, 6);
    check("one_shot", hits - base, 8'h01);
    rdchk("self_clear", CTRL, 8'h05);
    $display("test one_shot done");
    end_of_test();
  end
endmodule
